// ### bench/nvs_bus_master.sv
// Two-wire bus master model that drives the bus clock and data line.
`timescale 1ns/10ps
module nvs_bus_master (
  input wire logic mclk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic drive(input logic c, input logic d);
    hold(5);
    scl <= c;
    sda_rel <= d;
  endtask
  // Data moves only in mid low phase, far from either clock edge.
  task automatic bit_cycle(input logic b, output logic r);
    drive(1'b0, b);
    drive(1'b1, b);
    hold(5);
    r = sda_in;
    drive(1'b0, b);
  endtask
  task automatic start_cond();
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
  endtask
  task automatic stop_cond();
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    hold(5);
  endtask
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(v[i], r);
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask
  // A master that acks the last byte would clash with the next read bit.
  task automatic recv_byte(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      v[i] = r;
    end
    bit_cycle(~ack, r);
  endtask
endmodule // nvs_bus_master

// ### bench/testbench.sv
// Self-checking bench of the serial memory slave port.
`timescale 1ns/10ps
module testbench;
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEV_CODE = 4'hC;
  logic mclk = 1'b0;
  logic rst_n;
  logic write_protect;
  logic [2:0] device_select_pins = 3'h6;
  logic mem_wr_ready;
  logic [7:0] mem [0:8191];
  logic [7:0] mem_rd_data;
  logic [12:0] mem_rd_addr;
  logic mem_wr_valid, sda_o, sda_oe_n, scl, sda_rel, sda_wire;
  nvs_pkg::nvs_wr_s mem_wr;
  int n_fail = 0;
  int comparisons = 0;
  always #25 mclk = ~mclk;
  // The line has a pull-up: it is low only while a party pulls it.
  assign sda_wire = sda_rel & (sda_oe_n | sda_o);
  assign mem_rd_data = mem[mem_rd_addr];
  always @(posedge mclk) begin
    if (mem_wr_valid && mem_wr_ready) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
  end
  nvs_slave #(.DEV_TYPE(DEV_CODE)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
    .device_select_pins(device_select_pins), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr)
  );
  nvs_bus_master u_master (
    .mclk(mclk), .sda_in(sda_wire), .scl(scl), .sda_rel(sda_rel)
  );
  function automatic logic [7:0] init_val(input logic [12:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] dev_byte(input logic rw);
    return {DEV_CODE, device_select_pins, rw};
  endfunction
  task automatic chk_addr(input string what, input logic [12:0] e,
                          input logic [12:0] g);
    comparisons++;
    if (e !== g) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    chk_addr(what, {5'h00, e}, {5'h00, g});
  endtask
  task automatic chk_ack(input string what, input logic e, input logic g);
    chk_addr(what, {12'h000, e}, {12'h000, g});
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic open_write(input logic [15:0] a);
    logic ack;
    u_master.start_cond();
    u_master.send_byte(dev_byte(1'b0), ack);
    chk_ack("dev ack", 1'b1, ack);
    u_master.send_byte(a[15:8], ack);
    chk_ack("hi ack", 1'b1, ack);
    u_master.send_byte(a[7:0], ack);
    chk_ack("lo ack", 1'b1, ack);
    chk_addr("latch", a[12:0], mem_rd_addr);
  endtask
  task automatic open_read();
    logic ack;
    u_master.start_cond();
    u_master.send_byte(dev_byte(1'b1), ack);
    chk_ack("rd ack", 1'b1, ack);
  endtask
  task automatic write_data(input logic [7:0] d, input logic e);
    logic ack;
    u_master.send_byte(d, ack);
    chk_ack("data ack", e, ack);
  endtask
  task automatic read_data(input logic ack, input logic [7:0] e);
    logic [7:0] v;
    u_master.recv_byte(ack, v);
    chk_byte("rd data", e, v);
  endtask
  // Unused upper address bits are set to show they are dropped.
  task automatic t_write_wrap();
    open_write(16'hFFFE);
    write_data(8'hA5, 1'b1);
    chk_addr("inc", 13'h1FFF, mem_rd_addr);
    write_data(8'h3C, 1'b1);
    chk_addr("wrap", 13'h0000, mem_rd_addr);
    write_data(8'hC3, 1'b1);
    u_master.stop_cond();
    chk_byte("m1FFE", 8'hA5, mem[13'h1FFE]);
    chk_byte("m1FFF", 8'h3C, mem[13'h1FFF]);
    chk_byte("m0000", 8'hC3, mem[13'h0000]);
  endtask
  task automatic t_read();
    open_write(16'h1FFF);
    open_read();
    read_data(1'b1, 8'h3C);
    read_data(1'b0, 8'hC3);
    u_master.stop_cond();
    chk_addr("rd latch", 13'h0001, mem_rd_addr);
    open_read();
    read_data(1'b0, init_val(13'h0001));
    u_master.stop_cond();
  endtask
  task automatic t_select();
    logic ack;
    u_master.start_cond();
    u_master.send_byte({~DEV_CODE, device_select_pins, 1'b0}, ack);
    chk_ack("type", 1'b0, ack);
    u_master.send_byte(8'h00, ack);
    chk_ack("ignored", 1'b0, ack);
    u_master.stop_cond();
    for (int s = 0; s < 8; s++) begin
      device_select_pins <= s[2:0];
      u_master.hold(5);
      u_master.start_cond();
      u_master.send_byte({DEV_CODE, ~s[2:0], 1'b1}, ack);
      chk_ack("sel miss", 1'b0, ack);
      open_read();
      read_data(1'b0, init_val(13'h0002 + s[12:0]));
      u_master.stop_cond();
    end
    device_select_pins <= 3'h6;
    u_master.hold(5);
  endtask
  task automatic t_protect();
    write_protect <= 1'b1;
    open_write(16'h0100);
    write_data(8'h77, 1'b0);
    chk_addr("wp latch", 13'h0100, mem_rd_addr);
    u_master.stop_cond();
    chk_byte("wp mem", init_val(13'h0100), mem[13'h0100]);
    write_protect <= 1'b0;
  endtask
  task automatic t_abort();
    logic r;
    open_write(16'h0200);
    for (int i = 0; i < 4; i++) u_master.bit_cycle(1'b0, r);
    u_master.stop_cond();
    chk_byte("stop abort", init_val(13'h0200), mem[13'h0200]);
    chk_addr("stop latch", 13'h0200, mem_rd_addr);
    open_write(16'h0300);
    for (int i = 0; i < 7; i++) u_master.bit_cycle(1'b0, r);
    open_read();
    read_data(1'b0, init_val(13'h0300));
    u_master.stop_cond();
  endtask
  // The memory stalls; the third word finds the buffer full.
  task automatic t_stall();
    mem_wr_ready <= 1'b0;
    open_write(16'h0400);
    write_data(8'h11, 1'b1);
    write_data(8'h22, 1'b1);
    write_data(8'h33, 1'b0);
    u_master.stop_cond();
    chk_addr("full latch", 13'h0402, mem_rd_addr);
    chk_ack("wr valid", 1'b1, mem_wr_valid);
    chk_addr("head addr", 13'h0400, mem_wr.addr);
    chk_byte("head data", 8'h11, mem_wr.data);
    mem_wr_ready <= 1'b1;
    u_master.hold(4);
    chk_ack("drained", 1'b0, mem_wr_valid);
    chk_byte("m0400", 8'h11, mem[13'h0400]);
    chk_byte("m0401", 8'h22, mem[13'h0401]);
    chk_byte("m0402", init_val(13'h0402), mem[13'h0402]);
  endtask
  // A reset in mid-transfer clears the latch and drops the transfer.
  task automatic t_reset();
    open_write(16'h0123);
    rst_n <= 1'b0;
    u_master.hold(6);
    chk_ack("mid oe", 1'b1, sda_oe_n);
    chk_addr("mid latch", 13'h0000, mem_rd_addr);
    chk_ack("mid valid", 1'b0, mem_wr_valid);
    rst_n <= 1'b1;
    u_master.hold(4);
    u_master.stop_cond();
    open_read();
    read_data(1'b0, 8'hC3);
    u_master.stop_cond();
  endtask
  initial begin
    rst_n <= 1'b0;
    write_protect <= 1'b0;
    mem_wr_ready <= 1'b1;
    for (int i = 0; i < 8192; i++) mem[i] = init_val(i[12:0]);
    u_master.hold(6);
    chk_ack("rst oe", 1'b1, sda_oe_n);
    chk_addr("rst latch", 13'h0000, mem_rd_addr);
    rst_n <= 1'b1;
    u_master.hold(4);
    t_write_wrap();
    t_read();
    t_select();
    t_protect();
    t_abort();
    t_stall();
    t_reset();
    finish_test();
  end
  initial begin
    u_master.hold(40000);
    n_fail++;
    $display("watchdog ran out");
    finish_test();
  end
endmodule // testbench

// ### hdl/nvs_defs.svh
// Shared constants of the serial memory slave port.
`ifndef NVS_DEFS_SVH
`define NVS_DEFS_SVH
`define NVS_ADDR_W 13
`define NVS_SEL_W 3
`define NVS_TYPE_W 4
`define NVS_CNT_W 4
`define NVS_CNT_ZERO 4'h0
`define NVS_CNT_ONE 4'h1
`define NVS_BYTE_BITS 4'h8
`define NVS_ACK_CNT 4'h9
`define NVS_ADDR_RST 13'h0000
`define NVS_ADDR_ONE 13'h0001
`define NVS_BYTE_RST 8'h00
`define NVS_HI_RST 5'h00
`define NVS_TYPE_MSB 7
`define NVS_TYPE_LSB 4
`define NVS_SEL_MSB 3
`define NVS_SEL_LSB 1
`define NVS_RW_BIT 0
`define NVS_HI_MSB 4
`define NVS_DEPTH 2
`endif

// ### hdl/nvs_end.sv
// This compile unit holds no logic.

// ### hdl/nvs_fifo.sv
// Small valid/ready buffer held in flip-flops.
`timescale 1ns/10ps
module nvs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic do_in, do_out;
  if (DEPTH < 2) begin : g_chk
    $error("nvs_fifo: DEPTH must be at least two");
  end
  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign do_in = in_valid && in_ready;
  assign do_out = out_valid && out_ready;
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (do_in) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = (wp_r == LAST) ? '0 : wp_r + PW'(1);
    end
    if (do_out) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + PW'(1);
    end
    if (do_in && !do_out) begin
      cnt_nxt = cnt_r + (PW+1)'(1);
    end else if (do_out && !do_in) begin
      cnt_nxt = cnt_r - (PW+1)'(1);
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule // nvs_fifo

// ### hdl/nvs_pkg.sv
// Types shared by the serial memory slave port.
`include "nvs_defs.svh"
package nvs_pkg;
  typedef enum logic [2:0] {
    NVS_IDLE = 3'h0,
    NVS_DEV = 3'h1,
    NVS_AHI = 3'h2,
    NVS_ALO = 3'h3,
    NVS_WR = 3'h4,
    NVS_RD = 3'h5
  } nvs_state_e;
  typedef struct packed {
    logic [`NVS_ADDR_W-1:0] addr;
    logic [7:0] data;
  } nvs_wr_s;
  typedef logic [`NVS_CNT_W-1:0] nvs_cnt_t;
endpackage

// ### hdl/nvs_slave.sv
// Two-wire slave front end of an 8K x 8 nonvolatile memory.
//
// Contract
// - Data rising while clock high is stop; device returns to idle.
// - Stop abandons any pending operation without completing it.
// - Data falling while clock high is start; every transaction opens so.
// - Start at any time aborts and readies for a new address byte.
// - Data stable while clock high except start and stop.
// - After eight bits transmitter releases data; receiver pulls low to ack.
// - Data high in ack slot is a nack; operation ends.
// - Respond only when address byte bits 7-4 match the device type.
// - Address byte bits 3-1 must equal the device select pins.
// - Address byte bit 0: one reads, zero writes.
// - Memory address sent high byte first; only low 13 bits used.
// - Address latch persists; reads start from the latched value.
// - Latch increments after each data byte, before its ack slot.
// - Latch wraps from top location to zero; lengths unlimited. Code ends a write once its write buffer is full.
// - Read: shift eight bits, sample ack, continue on ack, end on nack.
// - Write: accept eight bits then ack; any number may follow. Code nacks a data byte while its write buffer is full.
// - Every byte is sent most significant bit first.
// - Array write after eighth bit, before ack; earlier abort writes nothing. Code only queues the word then; the array write waits for mem_wr_ready.
// - No write delay or page buffer; next transaction may start at once. Code queues writes in a buffer of FIFO_DEPTH words.
// - Write protect high: nack data bytes and keep the latch unchanged.
// - Sample inputs on clock rise, change output after clock fall.
`timescale 1ns/10ps
`include "nvs_defs.svh"
module nvs_slave #(
  // Device type code; the default value is arbitrary.
  parameter logic [`NVS_TYPE_W-1:0] DEV_TYPE = 4'h5,
  parameter int FIFO_DEPTH = `NVS_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic write_protect,
  input wire logic [`NVS_SEL_W-1:0] device_select_pins,
  output logic [`NVS_ADDR_W-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output nvs_pkg::nvs_wr_s mem_wr
);
  localparam int SW = 2 + 1 + `NVS_SEL_W;
  nvs_pkg::nvs_state_e st_r, st_nxt;
  nvs_pkg::nvs_cnt_t cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [`NVS_ADDR_W-1:0] addr_r, addr_nxt;
  logic [`NVS_HI_MSB:0] hi_r, hi_nxt;
  logic low_r, low_nxt, mack_r, mack_nxt;
  logic [SW-1:0] pins, pins_s, pins_p;
  logic scl_s, sda_s, scl_p, sda_p, wp_s;
  logic [`NVS_SEL_W-1:0] sel_s;
  logic scl_rise, scl_fall, start, stop;
  logic rx_state, accept, match, push, buf_ready;
  nvs_pkg::nvs_wr_s push_word;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("nvs_slave: FIFO_DEPTH must be at least two");
  end

  function automatic logic [`NVS_ADDR_W-1:0] addr_inc(
    input logic [`NVS_ADDR_W-1:0] a
  );
    // The carry out of the top bit is dropped, so the top location wraps.
    addr_inc = a + `NVS_ADDR_ONE;
  endfunction

  // All pins come from outside the clock domain.
  assign pins = {scl_i, sda_i, write_protect, device_select_pins};
  nvs_sync #(
    .W(SW)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(pins),
    .q(pins_s),
    .q_prev(pins_p)
  );
  assign scl_s = pins_s[SW-1];
  assign sda_s = pins_s[SW-2];
  assign wp_s = pins_s[SW-3];
  assign sel_s = pins_s[`NVS_SEL_W-1:0];
  assign scl_p = pins_p[SW-1];
  assign sda_p = pins_p[SW-2];

  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  // Data edges count as conditions only while the clock stays high.
  assign start = scl_s && scl_p && sda_p && !sda_s;
  assign stop = scl_s && scl_p && !sda_p && sda_s;

  assign rx_state = (st_r == nvs_pkg::NVS_DEV) || (st_r == nvs_pkg::NVS_AHI)
    || (st_r == nvs_pkg::NVS_ALO) || (st_r == nvs_pkg::NVS_WR);
  assign match = (sh_r[`NVS_TYPE_MSB:`NVS_TYPE_LSB] == DEV_TYPE)
    && (sh_r[`NVS_SEL_MSB:`NVS_SEL_LSB] == sel_s);

  // A full buffer is refused like a protected write, so no word is lost.
  always_comb begin
    unique case (st_r)
      nvs_pkg::NVS_DEV: accept = match;
      nvs_pkg::NVS_WR: accept = !wp_s && buf_ready;
      default: accept = rx_state;
    endcase
  end

  assign push = (st_r == nvs_pkg::NVS_WR) && scl_fall && !start && !stop
    && (cnt_r == `NVS_BYTE_BITS) && accept;
  assign push_word.addr = addr_r;
  assign push_word.data = sh_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    low_nxt = low_r;
    addr_nxt = addr_r;
    hi_nxt = hi_r;
    mack_nxt = mack_r;
    if (stop) begin
      st_nxt = nvs_pkg::NVS_IDLE;
      cnt_nxt = `NVS_CNT_ZERO;
      low_nxt = 1'b0;
    end else if (start) begin
      // A repeated start abandons a write after its address bytes.
      st_nxt = nvs_pkg::NVS_DEV;
      cnt_nxt = `NVS_CNT_ZERO;
      low_nxt = 1'b0;
    end else if (st_r == nvs_pkg::NVS_RD) begin
      if (scl_rise && cnt_r == `NVS_BYTE_BITS) begin
        mack_nxt = !sda_s;
        cnt_nxt = `NVS_ACK_CNT;
      end else if (scl_rise && cnt_r < `NVS_BYTE_BITS) begin
        cnt_nxt = cnt_r + `NVS_CNT_ONE;
      end else if (scl_fall && cnt_r == `NVS_BYTE_BITS) begin
        low_nxt = 1'b0;
        addr_nxt = addr_inc(addr_r);
      end else if (scl_fall && cnt_r == `NVS_ACK_CNT) begin
        cnt_nxt = `NVS_CNT_ZERO;
        if (mack_r) begin
          sh_nxt = mem_rd_data;
          low_nxt = !mem_rd_data[7];
        end else begin
          st_nxt = nvs_pkg::NVS_IDLE;
        end
      end else if (scl_fall && cnt_r != `NVS_CNT_ZERO) begin
        sh_nxt = {sh_r[6:0], 1'b1};
        low_nxt = !sh_r[6];
      end
    end else if (rx_state) begin
      if (scl_rise && cnt_r < `NVS_BYTE_BITS) begin
        sh_nxt = {sh_r[6:0], sda_s};
        cnt_nxt = cnt_r + `NVS_CNT_ONE;
      end else if (scl_fall && cnt_r == `NVS_BYTE_BITS) begin
        if (!accept) begin
          st_nxt = nvs_pkg::NVS_IDLE;
          cnt_nxt = `NVS_CNT_ZERO;
        end else begin
          cnt_nxt = `NVS_ACK_CNT;
          low_nxt = 1'b1;
          unique case (st_r)
            nvs_pkg::NVS_AHI: hi_nxt = sh_r[`NVS_HI_MSB:0];
            nvs_pkg::NVS_ALO: addr_nxt = {hi_r, sh_r};
            nvs_pkg::NVS_WR: addr_nxt = addr_inc(addr_r);
            default: hi_nxt = hi_r;
          endcase
        end
      end else if (scl_fall && cnt_r == `NVS_ACK_CNT) begin
        cnt_nxt = `NVS_CNT_ZERO;
        low_nxt = 1'b0;
        unique case (st_r)
          nvs_pkg::NVS_DEV: begin
            if (sh_r[`NVS_RW_BIT]) begin
              // Reads begin at whatever the latch holds.
              st_nxt = nvs_pkg::NVS_RD;
              sh_nxt = mem_rd_data;
              low_nxt = !mem_rd_data[7];
            end else begin
              st_nxt = nvs_pkg::NVS_AHI;
            end
          end
          nvs_pkg::NVS_AHI: st_nxt = nvs_pkg::NVS_ALO;
          default: st_nxt = nvs_pkg::NVS_WR;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= nvs_pkg::NVS_IDLE;
      cnt_r <= `NVS_CNT_ZERO;
      sh_r <= `NVS_BYTE_RST;
      low_r <= 1'b0;
      addr_r <= `NVS_ADDR_RST;
      hi_r <= `NVS_HI_RST;
      mack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      low_r <= low_nxt;
      addr_r <= addr_nxt;
      hi_r <= hi_nxt;
      mack_r <= mack_nxt;
    end
  end

  // The memory is expected to answer a read address within one cycle.
  assign mem_rd_addr = addr_r;
  assign sda_o = 1'b0;
  assign sda_oe_n = !low_r;

  nvs_fifo #(
    .W($bits(nvs_pkg::nvs_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(push_word),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_stop_to_idle: assert property (
    stop |=> st_r == nvs_pkg::NVS_IDLE && !low_r)
    else $error("stop did not return the port to idle");
  a_start_to_dev: assert property (
    start |=> st_r == nvs_pkg::NVS_DEV && cnt_r == `NVS_CNT_ZERO && !low_r)
    else $error("start did not ready the port for an address");
  a_drive_after_fall: assert property (
    $changed(low_r) |-> $past(scl_fall) || $past(start) || $past(stop))
    else $error("data line changed away from a clock fall");
  a_ack_drive_slot: assert property (
    rx_state && accept && scl_fall && !start && !stop
    && cnt_r == `NVS_BYTE_BITS |=> low_r && cnt_r == `NVS_ACK_CNT)
    else $error("accepted byte was not acknowledged");
  a_wp_refuse: assert property (
    st_r == nvs_pkg::NVS_WR && wp_s && scl_fall && !start && !stop
    && cnt_r == `NVS_BYTE_BITS |=> !low_r && $stable(addr_r)
    && st_r == nvs_pkg::NVS_IDLE)
    else $error("protected write was acknowledged or moved the latch");
  a_push_inc: assert property (
    push |=> addr_r == addr_inc($past(addr_r)) && low_r)
    else $error("write did not advance the latch by one");
  a_addr_mismatch: assert property (
    st_r == nvs_pkg::NVS_DEV && !match && scl_fall && !start && !stop
    && cnt_r == `NVS_BYTE_BITS |=> st_r == nvs_pkg::NVS_IDLE && !low_r)
    else $error("foreign address byte was answered");
  a_read_nack_end: assert property (
    st_r == nvs_pkg::NVS_RD && !mack_r && scl_fall && !start && !stop
    && cnt_r == `NVS_ACK_CNT |=> st_r == nvs_pkg::NVS_IDLE && !low_r)
    else $error("read went on after a nack");
  a_idle_released: assert property (
    st_r == nvs_pkg::NVS_IDLE |-> !low_r)
    else $error("data line driven while idle");
  a_read_dir: assert property (
    st_r == nvs_pkg::NVS_DEV && sh_r[`NVS_RW_BIT] && low_r && scl_fall
    && !start && !stop && cnt_r == `NVS_ACK_CNT |=> st_r == nvs_pkg::NVS_RD)
    else $error("read bit did not start a read");
  a_read_inc: assert property (
    st_r == nvs_pkg::NVS_RD && scl_fall && !start && !stop
    && cnt_r == `NVS_BYTE_BITS |=> addr_r == addr_inc($past(addr_r))
    && !low_r)
    else $error("read byte did not advance the latch");
  // The next byte is fetched at the fall that ends the master's ack.
  a_read_next: assert property (
    st_r == nvs_pkg::NVS_RD && mack_r && scl_fall && !start && !stop
    && cnt_r == `NVS_ACK_CNT |=> st_r == nvs_pkg::NVS_RD
    && sh_r == $past(mem_rd_data) && low_r == !sh_r[7])
    else $error("acknowledged read did not fetch the next byte");
  a_addr_load: assert property (
    st_r == nvs_pkg::NVS_ALO && scl_fall && !start && !stop
    && cnt_r == `NVS_BYTE_BITS |=> addr_r == {$past(hi_r), $past(sh_r)})
    else $error("low address byte did not load the latch");
  a_ack_release: assert property (
    (st_r == nvs_pkg::NVS_AHI || st_r == nvs_pkg::NVS_ALO
    || st_r == nvs_pkg::NVS_WR) && scl_fall && !start && !stop
    && cnt_r == `NVS_ACK_CNT |=> !low_r && cnt_r == `NVS_CNT_ZERO)
    else $error("acknowledge was held past its slot");

  c_byte_write: cover property (push);
  c_read_ack: cover property (
    st_r == nvs_pkg::NVS_RD && mack_r && scl_fall && cnt_r == `NVS_ACK_CNT);
  c_wp_refused: cover property (
    st_r == nvs_pkg::NVS_WR && wp_s && scl_fall && cnt_r == `NVS_BYTE_BITS);
  c_rep_start: cover property (st_r == nvs_pkg::NVS_WR && start);
endmodule // nvs_slave

// ### hdl/nvs_sync.sv
// Two-flop synchroniser with a delayed copy for edge detection.
`timescale 1ns/10ps
module nvs_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] q_prev
);
  logic [W-1:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
  if (W < 1) begin : g_chk
    $error("nvs_sync: W must be at least one");
  end
  // Stage one feeds stage two only; edges are taken from stages two and three.
  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
  assign q = s2_r;
  assign q_prev = s3_r;
endmodule // nvs_sync
